// >>> sstx_exec.sv
// subtract-with-borrow, nibble swap and table read/write execution unit.
// assumes: fetch unit holds INSN for a whole instruction (both cycles of a
// table op); file and program memories answer combinationally.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module sstx_exec
	import sstx_pkg::*;
#(
	parameter int PTR_WIDTH = PTR_W
)
(
	input  wire logic                 MCLK,
	input  wire logic                 SYS_RST,
	input  wire logic [INSN_W-1:0]    INSN,
	input  wire logic                 EXT_SET_ENABLE,
	input  wire logic [BANK_W-1:0]    BANK_SELECT,
	input  wire logic [DADDR_W-1:0]   INDEX_BASE,
	input  wire logic [DATA_W-1:0]    FILE_RDATA,
	input  wire logic [INSN_W-1:0]    PROG_RDATA,
	input  wire logic                 PTR_LOAD,
	input  wire logic [PTR_WIDTH-1:0] PTR_LOAD_VALUE,
	input  wire logic                 LATCH_LOAD,
	input  wire logic [DATA_W-1:0]    LATCH_LOAD_VALUE,
	input  wire logic                 STATUS_LOAD,
	input  wire logic [FLAG_W-1:0]    STATUS_LOAD_VALUE,
	output logic [DADDR_W-1:0]        FILE_ADDR,
	output logic                      FILE_RD,
	output logic                      FILE_WE,
	output logic [DATA_W-1:0]         FILE_WDATA,
	output logic [DATA_W-1:0]         WORK_REG,
	output logic [FLAG_W-1:0]         STATUS_FLAGS,
	output logic [PTR_WIDTH-1:0]      PROG_ADDR,
	output logic                      PROG_RD,
	output logic [PTR_WIDTH-1:0]      PROGRAM_BYTE_POINTER,
	output logic [DATA_W-1:0]         PROGRAM_BYTE_LATCH,
	output logic                      HOLD_WE,
	output logic [PTR_WIDTH-1:0]      HOLD_ADDR,
	output logic [DATA_W-1:0]         HOLD_WDATA,
	output logic                      BUSY
);
	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic logic [PTR_WIDTH-1:0] ptr_step(input logic [PTR_WIDTH-1:0] p,
		input logic dn);
		ptr_step = dn ? p - {{(PTR_WIDTH-1){1'b0}}, 1'b1} : p + {{(PTR_WIDTH-1){1'b0}}, 1'b1};
	endfunction

	function automatic logic [DATA_W-1:0] byte_pick(input logic [INSN_W-1:0] w, input logic hi);
		byte_pick = hi ? w[INSN_W-1:DATA_W] : w[DATA_W-1:0];
	endfunction

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	quarter_t quarter;
	logic     second_cycle;
	logic     op_subb;
	logic     op_swap;
	logic     op_tbl;
	logic     subtract_with_borrow_op;
	logic     nibble_exchange_op;
	logic     program_table_read_op;
	logic     program_table_write_op;
	logic [1:0] tbl_mode;
	logic     dest_file;
	logic     bank_bit;
	logic [FADDR_W-1:0] faddr;

	assign op_subb = INSN[OPC_MSB:OPC_LSB] == OPC_SUBB;
	assign op_swap = INSN[OPC_MSB:OPC_LSB] == OPC_SWAP;
	assign op_tbl  = INSN[OPC_MSB:TBL_HI_LSB] == OPC_TBL_HI;
	assign subtract_with_borrow_op = op_subb;
	assign nibble_exchange_op      = op_swap;
	assign program_table_read_op   = op_tbl & (INSN[TBL_HI_LSB-1:TBL_SEL_LSB] == TBL_RD_SEL);
	assign program_table_write_op  = op_tbl & (INSN[TBL_HI_LSB-1:TBL_SEL_LSB] == TBL_WR_SEL);
	assign tbl_mode  = INSN[TBL_SEL_LSB-1:0];
	assign dest_file = INSN[DEST_BIT];
	assign bank_bit  = INSN[BANK_BIT];
	assign faddr     = INSN[FADDR_W-1:0];

	sstx_quarter_gen u_quarter (
		.clk          (MCLK),
		.rst          (SYS_RST),
		.two_cycle    (program_table_read_op | program_table_write_op),
		.quarter      (quarter),
		.second_cycle (second_cycle)
	);

	// ----------------------------------------------------------------
	// file addressing
	// ----------------------------------------------------------------
	logic indexed_mode;
	logic [DADDR_W-1:0] access_addr;
	logic [DADDR_W-1:0] banked_addr;
	logic [DADDR_W-1:0] indexed_addr;
	logic byte_op;

	assign byte_op      = subtract_with_borrow_op | nibble_exchange_op;
	assign indexed_mode = EXT_SET_ENABLE & ~bank_bit & (faddr <= INDEX_LIMIT);
	assign access_addr  = (faddr < ACCESS_SPLIT) ? {{BANK_W{1'b0}}, faddr}
	                                             : {ACCESS_HI_BNK, faddr};
	assign banked_addr  = {BANK_SELECT, faddr};
	assign indexed_addr = INDEX_BASE + {{BANK_W{1'b0}}, faddr};
	assign FILE_ADDR    = indexed_mode ? indexed_addr : (bank_bit ? banked_addr : access_addr);
	assign FILE_RD      = byte_op & (quarter == QC_Q2);

	// ----------------------------------------------------------------
	// byte datapath
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] operand;
	logic [DATA_W-1:0] result;
	logic [DATA_W:0]   diff;
	logic [4:0]        low_diff;
	logic              carry_in;
	logic [FLAG_W-1:0] sub_flags;
	logic [DATA_W-1:0] next_work;
	logic [FLAG_W-1:0] next_flags;
	logic              write_q4;

	assign carry_in = STATUS_FLAGS[FLAG_C];
	assign diff     = {1'b0, operand} - {1'b0, WORK_REG} - {{DATA_W{1'b0}}, ~carry_in};
	assign low_diff = {1'b0, operand[3:0]} - {1'b0, WORK_REG[3:0]} - {4'h0, ~carry_in};
	always_comb begin
		sub_flags          = STATUS_FLAGS;
		sub_flags[FLAG_C]  = ~diff[DATA_W];
		sub_flags[FLAG_DC] = ~low_diff[4];
		sub_flags[FLAG_Z]  = diff[DATA_W-1:0] == {DATA_W{1'b0}};
		sub_flags[FLAG_N]  = diff[DATA_W-1];
		sub_flags[FLAG_OV] = (operand[DATA_W-1] ^ WORK_REG[DATA_W-1]) &
		                     (operand[DATA_W-1] ^ diff[DATA_W-1]);
	end

	assign write_q4   = byte_op & (quarter == QC_Q4);
	assign FILE_WE    = write_q4 & dest_file;
	assign FILE_WDATA = result;
	assign next_work  = (write_q4 & ~dest_file) ? result : WORK_REG;
	assign next_flags = STATUS_LOAD ? STATUS_LOAD_VALUE :
	                    (write_q4 & subtract_with_borrow_op) ? sub_flags : STATUS_FLAGS;

	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			operand <= '0;
			result  <= '0;
		end else begin
			if (FILE_RD)
				operand <= FILE_RDATA;
			if (byte_op & (quarter == QC_Q3))
				result <= subtract_with_borrow_op ? diff[DATA_W-1:0]
				                                  : {operand[3:0], operand[7:4]};
		end
	end

	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			WORK_REG     <= '0;
			STATUS_FLAGS <= '0;
		end else begin
			WORK_REG     <= next_work;
			STATUS_FLAGS <= next_flags;
		end
	end

	// ----------------------------------------------------------------
	// table pointer, latch and holding register port
	// ----------------------------------------------------------------
	logic tbl_op;
	logic pre_inc;
	logic post_step;
	logic [PTR_WIDTH-1:0] access_ptr;
	logic [PTR_WIDTH-1:0] next_ptr;
	logic [DATA_W-1:0]    next_latch;
	logic rd_q2;
	logic rd_q4;
	logic wr_q2;
	logic wr_q4;

	assign tbl_op    = program_table_read_op | program_table_write_op;
	assign pre_inc   = tbl_mode == PM_PREINC;
	assign post_step = (tbl_mode == PM_POSTINC) | (tbl_mode == PM_POSTDEC);
	assign access_ptr = pre_inc ? ptr_step(PROGRAM_BYTE_POINTER, 1'b0) : PROGRAM_BYTE_POINTER;
	assign rd_q2 = program_table_read_op & second_cycle & (quarter == QC_Q2);
	assign rd_q4 = program_table_read_op & second_cycle & (quarter == QC_Q4);
	assign wr_q2 = program_table_write_op & second_cycle & (quarter == QC_Q2);
	assign wr_q4 = program_table_write_op & second_cycle & (quarter == QC_Q4);

	assign PROG_ADDR = access_ptr;
	assign PROG_RD   = rd_q2;
	assign BUSY      = tbl_op & ~(second_cycle & (quarter == QC_Q4));

	always_comb begin
		next_ptr = PROGRAM_BYTE_POINTER;
		if (PTR_LOAD)
			next_ptr = PTR_LOAD_VALUE;
		else if (tbl_op & second_cycle & (quarter == QC_Q4)) begin
			if (pre_inc)
				next_ptr = access_ptr;
			else if (post_step)
				next_ptr = ptr_step(PROGRAM_BYTE_POINTER, tbl_mode == PM_POSTDEC);
		end
	end

	logic [DATA_W-1:0] fetched;
	logic [DATA_W-1:0] latch_seen;
	assign next_latch = LATCH_LOAD ? LATCH_LOAD_VALUE : (rd_q4 ? fetched : PROGRAM_BYTE_LATCH);

	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			PROGRAM_BYTE_POINTER <= '0;
			PROGRAM_BYTE_LATCH   <= '0;
			fetched              <= '0;
			latch_seen           <= '0;
		end else begin
			PROGRAM_BYTE_POINTER <= next_ptr;
			PROGRAM_BYTE_LATCH   <= next_latch;
			if (rd_q2)
				fetched <= byte_pick(PROG_RDATA, access_ptr[0]);
			if (wr_q2)
				latch_seen <= PROGRAM_BYTE_LATCH;
		end
	end

	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			HOLD_WE    <= 1'b0;
			HOLD_ADDR  <= '0;
			HOLD_WDATA <= '0;
		end else begin
			HOLD_WE    <= wr_q4;
			if (wr_q4) begin
				HOLD_ADDR  <= access_ptr;
				HOLD_WDATA <= latch_seen;
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_swap_flags_kept: assert property (@(posedge MCLK) disable iff (SYS_RST)
		nibble_exchange_op & ~STATUS_LOAD |=> STATUS_FLAGS == $past(STATUS_FLAGS))
		else $error("swap changed the flags");
	a_swap_value: assert property (@(posedge MCLK) disable iff (SYS_RST)
		nibble_exchange_op & (quarter == QC_Q4) |-> result == {operand[3:0], operand[7:4]})
		else $error("swap result wrong");
	a_subb_result: assert property (@(posedge MCLK) disable iff (SYS_RST)
		subtract_with_borrow_op & (quarter == QC_Q3) |=>
		result == $past(operand) - $past(WORK_REG) - {7'h00, ~$past(carry_in)})
		else $error("subtract result wrong");
	a_dest_work: assert property (@(posedge MCLK) disable iff (SYS_RST)
		byte_op & (quarter == QC_Q4) & ~dest_file |-> ~FILE_WE ##1 WORK_REG == $past(result))
		else $error("working register not written");
	a_bank_select: assert property (@(posedge MCLK) disable iff (SYS_RST)
		bank_bit |-> FILE_ADDR == {BANK_SELECT, faddr})
		else $error("banked address wrong");
	a_index_off: assert property (@(posedge MCLK) disable iff (SYS_RST)
		~EXT_SET_ENABLE & ~bank_bit |-> (FILE_ADDR[FADDR_W-1:0] == faddr) &
		((FILE_ADDR[DADDR_W-1:FADDR_W] == {BANK_W{1'b0}}) | (FILE_ADDR[DADDR_W-1:FADDR_W] == ACCESS_HI_BNK)))
		else $error("indexed mode without extended set");
	a_read_two_cycle: assert property (@(posedge MCLK) disable iff (SYS_RST)
		program_table_read_op & ~second_cycle & (quarter == QC_Q1) |-> ##5 PROG_RD)
		else $error("table read not in second cycle Q2");
	a_hold_q4: assert property (@(posedge MCLK) disable iff (SYS_RST)
		HOLD_WE |-> $past(second_cycle) & ($past(quarter) == QC_Q4))
		else $error("holding write outside Q4");
	a_ptr_post: assert property (@(posedge MCLK) disable iff (SYS_RST)
		rd_q4 & (tbl_mode == PM_POSTINC) & ~PTR_LOAD |=>
		PROGRAM_BYTE_POINTER == $past(PROGRAM_BYTE_POINTER) + 21'h000001)
		else $error("post increment wrong");

	localparam logic [PTR_WIDTH-1:0] PTR_ONE = {{(PTR_WIDTH-1){1'b0}}, 1'b1};
	a_subb_carry: assert property (@(posedge MCLK) disable iff (SYS_RST)
		write_q4 & subtract_with_borrow_op & ~STATUS_LOAD |=> STATUS_FLAGS[FLAG_C] ==
		({1'b0, $past(operand)} >= ({1'b0, $past(WORK_REG)} + {{DATA_W{1'b0}}, ~$past(carry_in)})))
		else $error("subtract carry wrong");
	a_subb_zero: assert property (@(posedge MCLK) disable iff (SYS_RST)
		write_q4 & subtract_with_borrow_op & ~STATUS_LOAD |=>
		STATUS_FLAGS[FLAG_Z] == ($past(result) == {DATA_W{1'b0}}))
		else $error("subtract zero flag wrong");
	a_subb_negative: assert property (@(posedge MCLK) disable iff (SYS_RST)
		write_q4 & subtract_with_borrow_op & ~STATUS_LOAD |=> STATUS_FLAGS[FLAG_N] == $past(result[DATA_W-1]))
		else $error("subtract negative flag wrong");
	a_swap_work: assert property (@(posedge MCLK) disable iff (SYS_RST)
		write_q4 & nibble_exchange_op & ~dest_file |=>
		WORK_REG == {$past(operand[3:0]), $past(operand[7:4])})
		else $error("swap not placed in working register");
	a_swap_wdata: assert property (@(posedge MCLK) disable iff (SYS_RST)
		FILE_WE & nibble_exchange_op |-> FILE_WDATA == {operand[3:0], operand[7:4]})
		else $error("swap file data wrong");
	a_read_q2: assert property (@(posedge MCLK) disable iff (SYS_RST)
		byte_op & (quarter == QC_Q1) |-> ~FILE_RD ##1 FILE_RD ##1 ~FILE_RD ##1
		(~FILE_RD & (FILE_WE == dest_file)))
		else $error("byte op quarter pattern wrong");
	a_index_addr: assert property (@(posedge MCLK) disable iff (SYS_RST)
		EXT_SET_ENABLE & ~bank_bit & (faddr <= INDEX_LIMIT) |->
		FILE_ADDR == INDEX_BASE + {{BANK_W{1'b0}}, faddr})
		else $error("indexed address wrong");
	a_access_upper: assert property (@(posedge MCLK) disable iff (SYS_RST)
		EXT_SET_ENABLE & ~bank_bit & (faddr > INDEX_LIMIT) |-> FILE_ADDR == {ACCESS_HI_BNK, faddr})
		else $error("upper access bank address wrong");
	a_tbl_flags: assert property (@(posedge MCLK) disable iff (SYS_RST)
		tbl_op & ~STATUS_LOAD |=> STATUS_FLAGS == $past(STATUS_FLAGS))
		else $error("table op changed the flags");
	a_ptr_postdec: assert property (@(posedge MCLK) disable iff (SYS_RST)
		tbl_op & second_cycle & (quarter == QC_Q4) & (tbl_mode == PM_POSTDEC) & ~PTR_LOAD |=>
		PROGRAM_BYTE_POINTER == $past(PROGRAM_BYTE_POINTER) - PTR_ONE)
		else $error("post decrement wrong");
	a_ptr_still: assert property (@(posedge MCLK) disable iff (SYS_RST)
		tbl_op & (tbl_mode == PM_NONE) & ~PTR_LOAD |=> PROGRAM_BYTE_POINTER == $past(PROGRAM_BYTE_POINTER))
		else $error("pointer moved in no change mode");
	a_hold_preinc: assert property (@(posedge MCLK) disable iff (SYS_RST)
		wr_q4 & pre_inc & ~PTR_LOAD |=> HOLD_WE & (HOLD_ADDR == PROGRAM_BYTE_POINTER) &
		(PROGRAM_BYTE_POINTER == $past(PROGRAM_BYTE_POINTER) + PTR_ONE))
		else $error("pre increment write address wrong");
	a_pick_byte: assert property (@(posedge MCLK) disable iff (SYS_RST)
		rd_q2 |=> fetched == ($past(PROG_ADDR[0]) ? $past(PROG_RDATA[INSN_W-1:DATA_W])
		                                           : $past(PROG_RDATA[DATA_W-1:0])))
		else $error("wrong program byte picked");
	a_hold_data: assert property (@(posedge MCLK) disable iff (SYS_RST)
		wr_q2 |-> ##2 ~HOLD_WE ##1 (HOLD_WE & (HOLD_WDATA == $past(PROGRAM_BYTE_LATCH, 3))))
		else $error("holding data not the latch seen in Q2");
	a_write_no_read: assert property (@(posedge MCLK) disable iff (SYS_RST)
		program_table_write_op |-> ~PROG_RD)
		else $error("table write read the array");

	c_subb: cover property (@(posedge MCLK) write_q4 & subtract_with_borrow_op);
	c_swap: cover property (@(posedge MCLK) write_q4 & nibble_exchange_op);
	c_program_table_read_op: cover property (@(posedge MCLK) rd_q4);
	c_program_table_write_op: cover property (@(posedge MCLK) wr_q4 & pre_inc);
	c_indexed: cover property (@(posedge MCLK) FILE_RD & indexed_mode);
endmodule

// >>> sstx_mem_model.sv
// partner model: data file, program memory and holding register beside sstx_exec.
// assumes: answers FILE_ADDR and PROG_ADDR combinationally, one clock, no reset.
`timescale 1ns/100ps
module sstx_mem_model
	import sstx_pkg::*;
(
	input  wire logic               clk,
	input  wire logic [DADDR_W-1:0] file_addr,
	input  wire logic               file_rd,
	input  wire logic               file_we,
	input  wire logic [DATA_W-1:0]  file_wdata,
	output logic      [DATA_W-1:0]  file_rdata,
	input  wire logic [PTR_W-1:0]   prog_addr,
	input  wire logic               prog_rd,
	output logic      [INSN_W-1:0]  prog_rdata,
	input  wire logic               hold_we,
	input  wire logic [PTR_W-1:0]   hold_addr,
	input  wire logic [DATA_W-1:0]  hold_wdata
);
	logic [DATA_W-1:0]  fmem [0:4095];
	logic [7:0]         junk     = 8'h6c;
	logic [DADDR_W-1:0] rd_addr  = 12'h000;
	logic [PTR_W-1:0]   hold_at  = 21'h000000;
	logic [DATA_W-1:0]  hold_val = 8'h00;
	logic [PTR_W-2:0]   word_addr;
	int                 rd_n = 0, we_n = 0, prd_n = 0, hwe_n = 0;
	// ----------------------------------------
	// answers and captures
	// ----------------------------------------
	// outside a read the buses carry a changing pattern, never the last value
	assign word_addr = prog_addr[PTR_W-1:1];
	assign file_rdata = file_rd ? fmem[file_addr] : junk;
	assign prog_rdata = prog_rd ? {word_addr[7:0] ^ 8'ha5, word_addr[7:0]} : {junk, ~junk};
	initial begin
		for (int i = 0; i < 4096; i++)
			fmem[i] = i[7:0];
	end
	always @(posedge clk) begin
		junk <= junk + 8'h3b;
		if (file_rd) begin
			rd_addr <= file_addr;
			rd_n <= rd_n + 1;
		end
		if (file_we) begin
			fmem[file_addr] <= file_wdata;
			we_n <= we_n + 1;
		end
		if (prog_rd)
			prd_n <= prd_n + 1;
		if (hold_we) begin
			hold_at <= hold_addr;
			hold_val <= hold_wdata;
			hwe_n <= hwe_n + 1;
		end
	end
endmodule

// >>> sstx_pkg.sv
// package: opcodes, field layouts, quarter-cycle codes and widths for the
// subtract/swap/table execution block.
// assumes: included before every file of the block.
package sstx_pkg;
	localparam int DATA_W     = 8;
	localparam int PTR_W      = 21;
	localparam int INSN_W     = 16;
	localparam int FADDR_W    = 8;
	localparam int BANK_W     = 4;
	localparam int DADDR_W    = 12;

	localparam logic [5:0]  OPC_SUBB     = 6'h16;
	localparam logic [5:0]  OPC_SWAP     = 6'h0e;
	localparam logic [11:0] OPC_TBL_HI   = 12'h000;
	localparam logic [1:0]  TBL_RD_SEL   = 2'h2;
	localparam logic [1:0]  TBL_WR_SEL   = 2'h3;

	localparam int OPC_MSB    = 15;
	localparam int OPC_LSB    = 10;
	localparam int DEST_BIT   = 9;
	localparam int BANK_BIT   = 8;
	localparam int TBL_HI_LSB = 4;
	localparam int TBL_SEL_LSB = 2;

	localparam logic [FADDR_W-1:0] INDEX_LIMIT   = 8'h5f;
	localparam logic [FADDR_W-1:0] ACCESS_SPLIT  = 8'h60;
	localparam logic [BANK_W-1:0]  ACCESS_HI_BNK = 4'hf;

	localparam logic [1:0] PM_NONE    = 2'h0;
	localparam logic [1:0] PM_POSTINC = 2'h1;
	localparam logic [1:0] PM_POSTDEC = 2'h2;
	localparam logic [1:0] PM_PREINC  = 2'h3;

	localparam int FLAG_C  = 0;
	localparam int FLAG_DC = 1;
	localparam int FLAG_Z  = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_N  = 4;
	localparam int FLAG_W  = 5;

	typedef enum logic [1:0] {
		QC_Q1 = 2'b00,
		QC_Q2 = 2'b01,
		QC_Q3 = 2'b10,
		QC_Q4 = 2'b11
	} quarter_t;
endpackage

// >>> sstx_quarter_gen.sv
// quarter-cycle sequencer: steps Q1..Q4 and marks the second cycle of
// two-cycle instructions.
// assumes: single MCLK domain, instruction presented at Q1 by the fetch unit.
`timescale 1ns/100ps
module sstx_quarter_gen
	import sstx_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     rst,
	input  wire logic     two_cycle,
	output quarter_t      quarter,
	output logic          second_cycle
);
	quarter_t next_quarter;
	logic     next_second;
	logic     cycle_end;

	assign cycle_end    = (quarter == QC_Q4);
	assign next_quarter = quarter_t'(quarter + 2'h1);
	assign next_second  = cycle_end ? (two_cycle & ~second_cycle) : second_cycle;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			quarter      <= QC_Q1;
			second_cycle <= 1'b0;
		end else begin
			quarter      <= next_quarter;
			second_cycle <= next_second;
		end
	end

	a_quarter_order: assert property (@(posedge clk) disable iff (rst)
		quarter == QC_Q4 |=> quarter == QC_Q1)
		else $error("quarter did not wrap to Q1");
endmodule

// >>> tb.sv
// testbench: feeds instruction slots to sstx_exec and checks results worked out here.
// assumes: sstx_mem_model stands on the memory side; slots are 4 or 8 clocks.
`timescale 1ns/100ps
module tb
	import sstx_pkg::*;
;
	logic               MCLK, SYS_RST, EXT_SET_ENABLE, PTR_LOAD, LATCH_LOAD, STATUS_LOAD;
	logic [INSN_W-1:0]  INSN, PROG_RDATA;
	logic [BANK_W-1:0]  BANK_SELECT;
	logic [DADDR_W-1:0] INDEX_BASE, FILE_ADDR, fa;
	logic [DATA_W-1:0]  FILE_RDATA, LATCH_LOAD_VALUE, FILE_WDATA, WORK_REG, PROGRAM_BYTE_LATCH, HOLD_WDATA;
	logic [PTR_W-1:0]   PTR_LOAD_VALUE, PROG_ADDR, PROGRAM_BYTE_POINTER, HOLD_ADDR, ea, ep;
	logic [FLAG_W-1:0]  STATUS_LOAD_VALUE, STATUS_FLAGS, exp_st;
	logic               FILE_RD, FILE_WE, PROG_RD, HOLD_WE, BUSY;
	logic [7:0]         exp_w, v, r;
	logic [12:0]        res;
	int                 failures = 0, num_checks = 0, n0, n1, n2, busy_cnt = 0;
	logic [7:0]         bf [6] = '{8'h0d, 8'h19, 8'h0d, 8'h03, 8'h0d, 8'h7f};
	logic [7:0]         sf [7] = '{8'h5f, 8'h60, 8'h33, 8'h5f, 8'h60, 8'h10, 8'h21};
	logic [20:0]        tp [4] = '{21'h00a356, 21'h00a357, 21'h000000, 21'h1fffff};
	localparam logic [5:0] BC = 6'b101111;
	localparam logic [5:0] BD = 6'b101110;

	sstx_exec DUT (.MCLK(MCLK), .SYS_RST(SYS_RST), .INSN(INSN), .EXT_SET_ENABLE(EXT_SET_ENABLE),
		.BANK_SELECT(BANK_SELECT), .INDEX_BASE(INDEX_BASE), .FILE_RDATA(FILE_RDATA), .PROG_RDATA(PROG_RDATA),
		.PTR_LOAD(PTR_LOAD), .PTR_LOAD_VALUE(PTR_LOAD_VALUE), .LATCH_LOAD(LATCH_LOAD),
		.LATCH_LOAD_VALUE(LATCH_LOAD_VALUE), .STATUS_LOAD(STATUS_LOAD), .STATUS_LOAD_VALUE(STATUS_LOAD_VALUE),
		.FILE_ADDR(FILE_ADDR), .FILE_RD(FILE_RD), .FILE_WE(FILE_WE), .FILE_WDATA(FILE_WDATA),
		.WORK_REG(WORK_REG), .STATUS_FLAGS(STATUS_FLAGS), .PROG_ADDR(PROG_ADDR), .PROG_RD(PROG_RD),
		.PROGRAM_BYTE_POINTER(PROGRAM_BYTE_POINTER), .PROGRAM_BYTE_LATCH(PROGRAM_BYTE_LATCH),
		.HOLD_WE(HOLD_WE), .HOLD_ADDR(HOLD_ADDR), .HOLD_WDATA(HOLD_WDATA), .BUSY(BUSY));
	sstx_mem_model PM (.clk(MCLK), .file_addr(FILE_ADDR), .file_rd(FILE_RD), .file_we(FILE_WE),
		.file_wdata(FILE_WDATA), .file_rdata(FILE_RDATA), .prog_addr(PROG_ADDR), .prog_rd(PROG_RD),
		.prog_rdata(PROG_RDATA), .hold_we(HOLD_WE), .hold_addr(HOLD_ADDR), .hold_wdata(HOLD_WDATA));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			failures++;
		end
	endtask
	task automatic end_sim();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// one instruction slot of n clocks; returns just after its last edge
	task automatic run(input logic [15:0] insn, input int n);
		INSN <= insn;
		repeat (n) @(posedge MCLK);
		#1;
	endtask
	// loads pointer, latch and flags during a no-operation slot
	task automatic prep(input logic [20:0] p, input logic [7:0] l, input logic [4:0] s);
		PTR_LOAD_VALUE <= p;
		LATCH_LOAD_VALUE <= l;
		STATUS_LOAD_VALUE <= s;
		PTR_LOAD <= 1'b1;
		LATCH_LOAD <= 1'b1;
		STATUS_LOAD <= 1'b1;
		run(16'h0000, 1);
		PTR_LOAD <= 1'b0;
		LATCH_LOAD <= 1'b0;
		STATUS_LOAD <= 1'b0;
		run(16'h0000, 3);
	endtask
	// {n, ov, z, dc, c, result}; carry and digit carry are set when no borrow
	function automatic logic [12:0] subb(input logic [7:0] f, w, input logic [4:0] st);
		logic [8:0] full;
		logic [4:0] lo;
		full = {1'b0, f} - {1'b0, w} - {8'h00, ~st[0]};
		lo = {1'b0, f[3:0]} - {1'b0, w[3:0]} - {4'h0, ~st[0]};
		return {full[7], (f[7] != w[7]) && (full[7] != f[7]), full[7:0] == 8'h00, ~lo[4], ~full[8], full[7:0]};
	endfunction
	function automatic logic [11:0] addr_of(input logic ext, a, input logic [7:0] f);
		if (!a && ext && f <= INDEX_LIMIT)
			return INDEX_BASE + {4'h0, f};
		if (a)
			return {BANK_SELECT, f};
		return {(f < ACCESS_SPLIT) ? 4'h0 : ACCESS_HI_BNK, f};
	endfunction

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		MCLK = 1'b0;
		forever #12.5 MCLK = ~MCLK;
	end
	// counts edges at which the block reports a table op in flight
	always @(posedge MCLK)
		if (BUSY === 1'b1)
			busy_cnt <= busy_cnt + 1;
	initial begin
		repeat (20000) @(posedge MCLK);
		failures++;
		end_sim();
	end
	initial begin
		{SYS_RST, EXT_SET_ENABLE, PTR_LOAD, LATCH_LOAD, STATUS_LOAD} = 5'b10000;
		{INSN, PTR_LOAD_VALUE, LATCH_LOAD_VALUE, STATUS_LOAD_VALUE} = '0;
		BANK_SELECT = 4'h7;
		INDEX_BASE = 12'h3f0;
		{exp_w, exp_st, ep} = '0;
		repeat (7) @(posedge MCLK);
		#1;
		chk("reset regs", 32'h0, {WORK_REG, STATUS_FLAGS, PROGRAM_BYTE_LATCH});
		chk("reset pointer", 32'h0, PROGRAM_BYTE_POINTER);
		@(posedge MCLK);
		SYS_RST <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			exp_st[0] = BC[i];
			prep(ep, 8'h55, exp_st);
			PM.fmem[12'h020] = bf[i];
			n0 = PM.we_n;
			res = subb(bf[i], exp_w, exp_st);
			run({OPC_SUBB, BD[i], 1'b0, 8'h20}, 4);
			exp_st = res[12:8];
			if (!BD[i])
				exp_w = res[7:0];
			chk("subb dest", res[7:0], BD[i] ? PM.fmem[12'h020] : WORK_REG);
			chk("subb work", exp_w, WORK_REG);
			chk("subb flags", exp_st, STATUS_FLAGS);
			chk("subb writes", BD[i], PM.we_n - n0);
		end
		for (int i = 0; i < 7; i++) begin
			EXT_SET_ENABLE <= (i >= 3);
			v = 8'h53 + i[7:0];
			r = {v[3:0], v[7:4]};
			fa = addr_of(i >= 3, i % 3 == 2, sf[i]);
			PM.fmem[fa] = v;
			n0 = PM.we_n;
			n1 = PM.rd_n;
			run({OPC_SWAP, i != 6, i % 3 == 2, sf[i]}, 4);
			if (i == 6)
				exp_w = r;
			chk("swap addr", fa, PM.rd_addr);
			chk("swap dest", (i != 6) ? r : v, PM.fmem[fa]);
			chk("swap work", exp_w, WORK_REG);
			chk("swap flags", exp_st, STATUS_FLAGS);
			chk("swap strobes", {i != 6, 8'h01}, {PM.we_n - n0 == 1, 8'(PM.rd_n - n1)});
		end
		EXT_SET_ENABLE <= 1'b0;
		for (int m = 0; m < 8; m++) begin
			prep(tp[m % 4], 8'hc0 + m[7:0], exp_st);
			n0 = PM.prd_n;
			n1 = PM.hwe_n;
			n2 = busy_cnt;
			run({OPC_TBL_HI, (m < 4) ? TBL_RD_SEL : TBL_WR_SEL, m[1:0]}, 8);
			chk("busy span", 7, busy_cnt - n2);
			if (m >= 4)
				run(16'h0000, 4);
			ea = (m % 4 == 3) ? tp[m % 4] + 21'h1 : tp[m % 4];
			ep = (m % 4 == 2) ? tp[m % 4] - 21'h1 : ((m % 4 == 0) ? tp[m % 4] : tp[m % 4] + 21'h1);
			r = ea[0] ? ea[8:1] ^ 8'ha5 : ea[8:1];
			chk("table pointer", ep, PROGRAM_BYTE_POINTER);
			chk("table flags", exp_st, STATUS_FLAGS);
			chk("array reads", m < 4, PM.prd_n - n0);
			if (m < 4)
				chk("read latch", r, PROGRAM_BYTE_LATCH);
			else begin
				chk("hold data", 8'hc0 + m[7:0], PM.hold_val);
				chk("hold write", {ea, 8'h01}, {PM.hold_at, 8'(PM.hwe_n - n1)});
			end
		end
		end_sim();
	end
endmodule
